// File: src/tsr_consts.vh
// Constants for the two-wire temperature sensor register block.
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH
`define TSR_CMD_READ_TEMPERATURE 8'h00
`define TSR_CMD_CONFIG_ACCESS 8'h01
`define TSR_TEMP_RESET 8'h00
`define TSR_SETUP_RESET 8'h00
`define TSR_STANDBY_BIT 7
`define TSR_READY_BIT 6
`define TSR_ADDR_BASE 5'h13
`define TSR_TEMP_MAX 8'h7f
`define TSR_CONV_TIME_US 125000
`define TSR_CONV_CYCLES (`TSR_CONV_TIME_US * 100)
`define TSR_READY_DELAY 2
`endif

// File: src/tsr_conv_timer.v
// Conversion pacing, saturation and data-ready sequencing.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.vh"
module tsr_conv_timer #(
  parameter CONV_CYCLES = `TSR_CONV_CYCLES
) (
  input wire core_clk,
  input wire nrst,
  input wire standby_request,
  input wire signed [9:0] sensor_value,
  output reg [7:0] temp_ff,
  output reg ready_ff
);
  reg [31:0] cnt_ff;
  reg [1:0] ldly_ff;
  wire [31:0] last_cnt;
  wire [7:0] sat_value;
  assign last_cnt = CONV_CYCLES - 1;
  // Values above the representable range saturate at the most positive code.
  assign sat_value = (sensor_value > 10'sd127) ? `TSR_TEMP_MAX :
    (sensor_value < -10'sd128) ? 8'h80 : sensor_value[7:0];
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      temp_ff <= `TSR_TEMP_RESET;
      ldly_ff <= 2'h0;
    end
    else if (standby_request)
    begin
      cnt_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      ldly_ff <= 2'h0;
    end
    else
    begin
      ldly_ff <= {ldly_ff[0], 1'b0};
      if (cnt_ff == last_cnt)
      begin
        cnt_ff <= 32'h0000_0000;
        ready_ff <= 1'b1;
        ldly_ff <= 2'h1;
      end
      else
        cnt_ff <= cnt_ff + 32'h0000_0001;
      if (ldly_ff[0])
        temp_ff <= sat_value;
    end
  end
endmodule // tsr_conv_timer
`default_nettype wire

// File: src/tsr_sensor_regs.v
// Two-wire slave interface and register set of the temperature sensor.
// Operation
// - Ignore bus until start condition seen.
// - Acknowledge only matching seven-bit address.
// - Eighth address bit: one read, zero write.
// - Device pulls data low on ninth clock.
// - Acknowledge data bytes written only to the configuration register.
// - Command 00h temperature, 01h configuration.
// - Standby bit7, ready bit6, reserved zero.
// - Ready clears at reset and standby.
// - Temperature register holds two's-complement result.
// - Results update automatically without requests.
// - One step is one degree Celsius.
// - Every register is eight bits.
// - Temperature loads right after ready rises.
// - Bytes travel most significant bit first.
// - Data changes only while clock low.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.vh"
module tsr_sensor_regs #(
  parameter CONV_CYCLES = `TSR_CONV_CYCLES
) (
  input wire core_clk,
  input wire nrst,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n,
  input wire address_select_high,
  input wire address_select_low,
  input wire signed [9:0] sensor_value,
  output wire standby_request
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_ADDR = 6'b000010;
  localparam ST_ACK = 6'b000100;
  localparam ST_WRITE = 6'b001000;
  localparam ST_READ = 6'b010000;
  localparam ST_MACK = 6'b100000;
  reg [5:0] state_ff;
  reg [5:0] nxt_state;
  reg [1:0] scl_sync_ff;
  reg [1:0] sda_sync_ff;
  reg scl_d_ff;
  reg sda_d_ff;
  reg [7:0] shift_ff;
  reg [7:0] nxt_shift;
  reg [3:0] bit_ff;
  reg [3:0] nxt_bit;
  reg rw_ff;
  reg nxt_rw;
  reg cmd_phase_ff;
  reg nxt_cmd_phase;
  reg [7:0] cmd_ff;
  reg [7:0] nxt_cmd;
  reg standby_ff;
  reg nxt_standby;
  reg ack_ff;
  reg nxt_ack;
  reg nxt_sda_o;
  reg nxt_sda_oe_n;
  reg [1:0] aa_meta_ff;
  reg [1:0] aa_ff;
  wire [7:0] temp_value;
  wire ready;
  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [6:0] own_addr;
  function [7:0] read_mux;
    input [7:0] cmd;
    input [7:0] temp;
    input stby;
    input rdy;
    begin
      if (cmd == `TSR_CMD_READ_TEMPERATURE)
        read_mux = temp;
      else if (cmd == `TSR_CMD_CONFIG_ACCESS)
        read_mux = {stby, rdy, 6'h00};
      else
        read_mux = 8'h00;
    end
  endfunction
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_cond = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_cond = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign own_addr = {`TSR_ADDR_BASE, aa_ff};
  assign standby_request = standby_ff;
  tsr_conv_timer #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .core_clk(core_clk),
    .nrst(nrst),
    .standby_request(standby_ff),
    .sensor_value(sensor_value),
    .temp_ff(temp_value),
    .ready_ff(ready)
  );
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_ff <= 2'b11;
      sda_sync_ff <= 2'b11;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      aa_meta_ff <= 2'b00;
      aa_ff <= 2'b00;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      aa_meta_ff <= {address_select_high, address_select_low};
      aa_ff <= aa_meta_ff;
    end
  end
  always @*
  begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bit = bit_ff;
    nxt_rw = rw_ff;
    nxt_cmd_phase = cmd_phase_ff;
    nxt_cmd = cmd_ff;
    nxt_standby = standby_ff;
    nxt_ack = ack_ff;
    nxt_sda_o = sda_o;
    nxt_sda_oe_n = sda_oe_n;
    if (start_cond)
    begin
      nxt_state = ST_ADDR;
      nxt_bit = 4'h0;
      nxt_sda_oe_n = 1'b1;
    end
    else if (stop_cond)
    begin
      nxt_state = ST_IDLE;
      nxt_sda_oe_n = 1'b1;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          nxt_sda_oe_n = 1'b1;
        ST_ADDR, ST_WRITE:
        begin
          if (scl_rise)
          begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bit = bit_ff + 4'h1;
          end
          if (scl_fall && bit_ff == 4'h8)
          begin
            nxt_bit = 4'h0;
            nxt_ack = 1'b1;
            if (state_ff == ST_ADDR)
            begin
              nxt_rw = shift_ff[0];
              nxt_cmd_phase = ~shift_ff[0];
              if (shift_ff[7:1] != own_addr)
                nxt_ack = 1'b0;
            end
            else if (cmd_phase_ff)
            begin
              nxt_cmd = shift_ff;
              nxt_cmd_phase = 1'b0;
            end
            else if (cmd_ff == `TSR_CMD_CONFIG_ACCESS)
              nxt_standby = shift_ff[`TSR_STANDBY_BIT];
            else
              nxt_ack = 1'b0;
            if (nxt_ack)
            begin
              nxt_state = ST_ACK;
              nxt_sda_o = 1'b0;
              nxt_sda_oe_n = 1'b0;
            end
            else
              nxt_state = ST_IDLE;
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_ff)
            begin
              nxt_state = ST_READ;
              nxt_shift = read_mux(cmd_ff, temp_value, standby_ff, ready);
              nxt_sda_o = nxt_shift[7];
              nxt_sda_oe_n = 1'b0;
            end
            else
            begin
              nxt_state = ST_WRITE;
              nxt_sda_oe_n = 1'b1;
            end
          end
        end
        ST_READ:
        begin
          if (scl_fall)
          begin
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7)
            begin
              nxt_state = ST_MACK;
              nxt_sda_oe_n = 1'b1;
              nxt_bit = 4'h0;
            end
            else
            begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_o = shift_ff[6];
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise && sda_s)
            nxt_state = ST_IDLE;
          else if (scl_rise)
            nxt_state = ST_ACK;
        end
        default:
          nxt_state = ST_IDLE;
      endcase
    end
  end
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      bit_ff <= 4'h0;
      rw_ff <= 1'b0;
      cmd_phase_ff <= 1'b0;
      cmd_ff <= `TSR_CMD_READ_TEMPERATURE;
      standby_ff <= 1'b0;
      ack_ff <= 1'b0;
      sda_o <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bit_ff <= nxt_bit;
      rw_ff <= nxt_rw;
      cmd_phase_ff <= nxt_cmd_phase;
      cmd_ff <= nxt_cmd;
      standby_ff <= nxt_standby;
      ack_ff <= nxt_ack;
      sda_o <= nxt_sda_o;
      sda_oe_n <= nxt_sda_oe_n;
    end
  end
endmodule // tsr_sensor_regs
`default_nettype wire

// File: sim/tsr_checker.sv
// Port checks for the two-wire sensor register block.
`timescale 1ns/1ps
`default_nettype none
module tsr_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic standby_request
);
  logic [4:0] hi_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Counts how long the bus clock has stayed high.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst || !scl_i)
      hi_ff <= 5'h0;
    else if (hi_ff != 5'h1f)
      hi_ff <= hi_ff + 5'h1;
  end
  a_reset_quiet: assert property ($rose(nrst) |-> sda_oe_n && !standby_request)
    else $error("drive or standby active after reset");
  a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("drive enable changed with clock high");
  a_data_scl_low: assert property ($changed(sda_o) && !sda_oe_n |-> !scl_i)
    else $error("driven data changed with clock high");
  a_high_stable: assert property ($rose(scl_i) |-> $stable(sda_oe_n)[*4])
    else $error("drive enable moved in clock high phase");
  a_ack_stands: assert property ($fell(sda_oe_n) |-> !sda_oe_n[*8])
    else $error("drive released too early");
  a_stop_released: assert property (scl_i && $rose(sda_i) |-> sda_oe_n[*8])
    else $error("drive after stop");
  a_stby_acked: assert property ($changed(standby_request) |-> ##[0:8] !sda_oe_n)
    else $error("standby changed without ack");
  a_idle_released: assert property (hi_ff > 5'h0c |-> sda_oe_n)
    else $error("drive on idle bus");
endmodule // tsr_checker
`default_nettype wire

// File: sim/tsr_host.sv
// Behavioural bus master driving the two-wire link.
`timescale 1ns/1ps
`default_nettype none
module tsr_host (
  output logic scl,
  output logic sda_h,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
  begin
    sda_h = b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
    #40;
  end
  endtask
  task automatic start;
  begin
    sda_h = 1'b1;
    #40 scl = 1'b1;
    #80 sda_h = 1'b0;
    #80 scl = 1'b0;
    #40;
  end
  endtask
  task automatic stop;
  begin
    sda_h = 1'b0;
    #40 scl = 1'b1;
    #80 sda_h = 1'b1;
    #80;
  end
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(d[i], q[i]);
    bit_io(a, k);
  end
  endtask
endmodule // tsr_host
`default_nettype wire

// File: sim/tb_tsr_sensor_regs.sv
// Self-checking bench for the sensor register block.
`timescale 1ns/1ps
`default_nettype none
module tb_tsr_sensor_regs;
  localparam logic [6:0] DEV = 7'h4d;
  logic core_clk, nrst, sda_o, sda_oe_n, standby_request, scl, sda_h, k;
  logic signed [9:0] sensor_value;
  logic [7:0] q;
  logic sel_hi, sel_lo;
  integer fail_count, tests_run;
  wire logic sda = sda_h & (sda_oe_n | sda_o);
  tsr_sensor_regs #(.CONV_CYCLES(50)) uut (.core_clk(core_clk), .nrst(nrst), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .address_select_high(sel_hi),
    .address_select_low(sel_lo), .sensor_value(sensor_value), .standby_request(standby_request));
  tsr_host host (.scl(scl), .sda_h(sda_h), .sda(sda));
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  end
  endtask
  task automatic head(input logic [7:0] b, input logic e);
  begin
    host.start();
    host.xfer(b, 1'b1, q, k);
    chk("address ack", {7'h00, e}, {7'h00, k});
  end
  endtask
  task automatic cmd(input logic [7:0] c);
  begin
    head({DEV, 1'b0}, 1'b0);
    host.xfer(c, 1'b1, q, k);
    chk("command ack", 8'h00, {7'h00, k});
  end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic e);
  begin
    cmd(c);
    host.xfer(d, 1'b1, q, k);
    chk("data ack", {7'h00, e}, {7'h00, k});
    host.stop();
  end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
  begin
    cmd(c);
    head({DEV, 1'b1}, 1'b0);
    host.xfer(8'hff, 1'b1, q, k);
    host.stop();
    chk("read data", e, q);
  end
  endtask
  task automatic test_done;
  begin
    $display("checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (100000) @(posedge core_clk);
    fail_count = fail_count + 1;
    test_done();
  end
  initial
  begin
    nrst = 1'b0;
    sel_hi = 1'b0;
    sel_lo = 1'b1;
    sensor_value = 10'sd25;
    fail_count = 0;
    tests_run = 0;
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    chk("standby", 8'h00, {7'h00, standby_request});
    repeat (4) @(negedge core_clk);
    head({7'h4c, 1'b0}, 1'b1);
    host.stop();
    rd(8'h00, 8'h19);
    rd(8'h01, 8'h40);
    sensor_value = 10'sd200;
    rd(8'h00, 8'h7f);
    sensor_value = -10'sd25;
    rd(8'h00, 8'he7);
    wr(8'h01, 8'hff, 1'b0);
    chk("standby", 8'h01, {7'h00, standby_request});
    rd(8'h01, 8'h80);
    sensor_value = 10'sd5;
    rd(8'h00, 8'he7);
    wr(8'h01, 8'h00, 1'b0);
    chk("standby", 8'h00, {7'h00, standby_request});
    wr(8'h00, 8'h55, 1'b1);
    rd(8'h00, 8'h05);
    wr(8'h01, 8'h80, 1'b0);
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    chk("standby", 8'h00, {7'h00, standby_request});
    repeat (4) @(negedge core_clk);
    rd(8'h01, 8'h40);
    sel_hi = 1'b1;
    sel_lo = 1'b0;
    repeat (4) @(negedge core_clk);
    head({DEV, 1'b0}, 1'b1);
    host.stop();
    head({7'h4e, 1'b0}, 1'b0);
    host.stop();
    test_done();
  end
endmodule // tb_tsr_sensor_regs
bind tsr_sensor_regs tsr_checker chk_i (.core_clk(core_clk), .nrst(nrst), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .standby_request(standby_request));
`default_nettype wire
